/* File: ppfs_pkg.sv */
package ppfs_pkg;

  // ---------------------------------------------------------------
  // register map, byte addresses on the 32-bit bus
  // ---------------------------------------------------------------
  localparam logic [31:0] FSEL_OFF = 32'h0000_0000;
  localparam logic [31:0] PBDIR_OFF = 32'h0000_0004;

  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [15:0] FSEL_RST = 16'hff95;
  localparam logic [15:0] FSEL_RSVD = 16'haa00;
  localparam logic [15:0] PBDIR_RST = 16'h0000;
  localparam int PIN7_BIT = 14;
  localparam int PIN6_BIT = 12;
  localparam int PIN5_BIT = 10;
  localparam int PIN4_BIT = 8;
  localparam int PIN3_LSB = 6;
  localparam int PIN2_LSB = 4;
  localparam int PIN1_LSB = 2;
  localparam int PIN0_LSB = 0;

  // two-bit function codes, shared by pins 0 to 3
  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_ALT1 = 2'h1;
  localparam logic [1:0] FN_ALT2 = 2'h2;
  localparam logic [1:0] FN_RSVD = 2'h3;

  // ---------------------------------------------------------------
  // bus constants
  // ---------------------------------------------------------------
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [31:0] HRDATA_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // drive of one pin: value and active-low output enable
  typedef struct packed {
    logic out;
    logic oe_n;
  } ppfs_drv_t;

  // register access handed from the bus slave to the register file
  typedef struct packed {
    logic wr;
    logic load;
    logic [31:0] addr;
  } ppfs_acc_t;

  // peripheral signals offered to the lower eight pins of port a
  typedef struct packed {
    logic bus_grant_ack_n;
    logic read_strobe_n;
    logic upper_write_strobe_n;
    logic lower_write_strobe_n;
    logic chip_select_seven_n;
    logic chip_select_six_n;
    logic chip_select_five_n;
    logic chip_select_four_n;
    logic row_addr_strobe_n;
    logic timer0_capcomp_a_out;
    logic timer0_capcomp_a_oe_n;
    logic timer0_capcomp_b_out;
    logic timer0_capcomp_b_oe_n;
  } ppfs_pa_periph_t;

endpackage : ppfs_pkg

/* File: ppfs_sync.sv */
`timescale 1ns/1ps
module ppfs_sync import ppfs_pkg::*; #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ppfs_sync_st_t;

  ppfs_sync_st_t st;
  ppfs_sync_st_t next_st;

  // ---------------------------------------------------------------
  // two-flop chain; meta feeds only the second flop
  // ---------------------------------------------------------------
  always_comb begin
    next_st.meta = async_i;
    next_st.stable = st.meta;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stable;

endmodule : ppfs_sync

/* File: ppfs_ahb_slave.sv */
`timescale 1ns/1ps
module ppfs_ahb_slave import ppfs_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // ahb-lite address phase
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  // handshake and register access
  output logic hreadyout_o,
  output ppfs_acc_t acc_o
);

  typedef struct packed {
    logic wr_pend;
    logic rd_pend;
    logic ready;
    logic [31:0] addr;
  } ppfs_ahb_st_t;

  ppfs_ahb_st_t st;
  ppfs_ahb_st_t next_st;
  logic take;

  // ---------------------------------------------------------------
  // transfer tracking
  // ---------------------------------------------------------------
  // reads insert one wait state so that read data leaves a flop
  always_comb begin
    take = hsel_i & htrans_i[1] & hready_i;
    next_st = st;
    next_st.wr_pend = 1'b0;
    next_st.rd_pend = 1'b0;
    next_st.ready = 1'b1;
    if (take) begin
      next_st.addr = haddr_i;
      next_st.wr_pend = hwrite_i;
      next_st.rd_pend = ~hwrite_i;
      next_st.ready = hwrite_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '{wr_pend: 1'b0, rd_pend: 1'b0, ready: 1'b1, addr: 32'h0000_0000};
    end else begin
      st <= next_st;
    end
  end

  // writes commit at the end of their data phase
  assign hreadyout_o = st.ready;
  assign acc_o.wr = st.wr_pend;
  assign acc_o.load = st.rd_pend;
  assign acc_o.addr = st.addr;

endmodule : ppfs_ahb_slave

/* File: ppfs_top.sv */
// Behaviour
// RULE1 - fsel bits 15, 13, 11, 9 read as one; software writes ones there
// RULE2 - bit 14: 0 pin 7 general io, 1 bus grant acknowledge; resets to 1
// RULE3 - bit 12: 0 pin 6 general io, 1 read strobe low active; resets 1
// RULE4 - bit 10: 0 pin 5 general io, 1 upper write or lower byte strobe
// RULE5 - bit 8: 0 pin 4 general io, 1 lower or single write strobe
// RULE6 - bits 7:6 pin 3: io, chip select seven, wait input (reset), reserved
// RULE7 - pin 3 pull-up only in wait function, enabled by bus controller
// RULE8 - bits 5:4 pin 2: io, chip select six (reset), timer b, reserved
// RULE9 - bits 3:2 pin 1: io, chip select five (reset), row strobe, reserved
// RULE10 - bits 1:0 pin 0: io, chip select four (reset), timer a, reserved
// RULE11 - port b direction: sixteen bits, one makes output, zero input
// RULE12 - direction counts only in io, timer or serial clock function
// RULE13 - port b direction clears on power-on reset only
// RULE14 - function register loads its reset pattern on power-on reset only
// RULE15 - peripheral functions own pin drive, enable and input
`timescale 1ns/1ps
module ppfs_top import ppfs_pkg::*; (
  // clock and power-on reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [1:0] hresp_o,
  output logic [31:0] hrdata_o,
  // port a lower byte, general io side
  input wire logic [7:0] gpio_a_out_i,
  input wire logic [7:0] gpio_a_dir_i,
  output logic [7:0] gpio_a_in_o,
  // port a lower byte, peripheral side
  input wire ppfs_pa_periph_t pa_periph_i,
  input wire logic wait_pullup_en_i,
  output logic wait_n_o,
  output logic timer0_capcomp_a_in_o,
  output logic timer0_capcomp_b_in_o,
  // port a lower byte pins
  input wire logic [7:0] pa_pin_i,
  output logic [7:0] pa_pin_o,
  output logic [7:0] pa_pin_oe_n_o,
  output logic pa3_pullup_o,
  // port b, function side
  input wire logic [15:0] pb_dir_en_i,
  input wire logic [15:0] pb_src_out_i,
  input wire logic [15:0] pb_periph_oe_n_i,
  output logic [15:0] pb_in_o,
  // port b pins
  input wire logic [15:0] pb_pin_i,
  output logic [15:0] pb_pin_o,
  output logic [15:0] pb_pin_oe_n_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] fsel;
    logic [15:0] pbdir;
    logic [31:0] hrdata;
    logic [7:0] pa_out;
    logic [7:0] pa_oe_n;
    logic pa_pullup;
    logic [15:0] pb_out;
    logic [15:0] pb_oe_n;
    logic [7:0] gpio_a_in;
    logic [15:0] pb_in;
    logic wait_n;
    logic tmr_a_in;
    logic tmr_b_in;
  } ppfs_top_st_t;

  // pins float (inputs) during reset until the registers steer them
  localparam ppfs_top_st_t ST_RST = '{
    fsel: FSEL_RST,
    pbdir: PBDIR_RST,
    hrdata: HRDATA_RST,
    pa_out: 8'hff,
    pa_oe_n: 8'hff,
    pa_pullup: 1'b0,
    pb_out: 16'h0000,
    pb_oe_n: 16'hffff,
    gpio_a_in: 8'h00,
    pb_in: 16'h0000,
    wait_n: 1'b1,
    tmr_a_in: 1'b0,
    tmr_b_in: 1'b0
  };

  ppfs_top_st_t st;
  ppfs_top_st_t next_st;
  ppfs_acc_t acc;
  logic [7:0] pa_sync;
  logic [15:0] pb_sync;
  ppfs_drv_t pa_drv [8];
  logic [1:0] code3;
  logic [1:0] code2;
  logic [1:0] code1;
  logic [1:0] code0;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic ppfs_drv_t gpio_drv(input logic out, input logic dir);
    gpio_drv = '{out: out, oe_n: ~dir};
  endfunction : gpio_drv

  // reserved codes leave the pin as a plain input, never driven
  function automatic ppfs_drv_t pick2(input logic [1:0] code, input ppfs_drv_t io,
                                      input ppfs_drv_t alt1, input ppfs_drv_t alt2);
    case (code)
      FN_GPIO: pick2 = io;
      FN_ALT1: pick2 = alt1;
      FN_ALT2: pick2 = alt2;
      default: pick2 = '{out: 1'b1, oe_n: 1'b1};
    endcase
  endfunction : pick2

  function automatic logic hit(input logic [31:0] addr, input logic [31:0] off);
    hit = (addr[31:2] == off[31:2]);
  endfunction : hit

  // ---------------------------------------------------------------
  // bus slave and input synchronisers
  // ---------------------------------------------------------------
  ppfs_ahb_slave u_bus (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hready_i(hready_i),
    .hreadyout_o(hreadyout_o),
    .acc_o(acc)
  );

  // pins come from outside the clock domain
  ppfs_sync #(.W(24)) u_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .async_i({pb_pin_i, pa_pin_i}),
    .sync_o({pb_sync, pa_sync})
  );

  assign code3 = st.fsel[PIN3_LSB +: 2];
  assign code2 = st.fsel[PIN2_LSB +: 2];
  assign code1 = st.fsel[PIN1_LSB +: 2];
  assign code0 = st.fsel[PIN0_LSB +: 2];

  // ---------------------------------------------------------------
  // port a pin selection
  // ---------------------------------------------------------------
  // strobes and chip selects always drive; wait is input only
  always_comb begin
    pa_drv[7] = st.fsel[PIN7_BIT] ? ppfs_drv_t'{out: pa_periph_i.bus_grant_ack_n, oe_n: 1'b0}
                                  : gpio_drv(gpio_a_out_i[7], gpio_a_dir_i[7]); // RULE2
    pa_drv[6] = st.fsel[PIN6_BIT] ? ppfs_drv_t'{out: pa_periph_i.read_strobe_n, oe_n: 1'b0}
                                  : gpio_drv(gpio_a_out_i[6], gpio_a_dir_i[6]); // RULE3
    pa_drv[5] = st.fsel[PIN5_BIT] ? ppfs_drv_t'{out: pa_periph_i.upper_write_strobe_n, oe_n: 1'b0}
                                  : gpio_drv(gpio_a_out_i[5], gpio_a_dir_i[5]); // RULE4
    pa_drv[4] = st.fsel[PIN4_BIT] ? ppfs_drv_t'{out: pa_periph_i.lower_write_strobe_n, oe_n: 1'b0}
                                  : gpio_drv(gpio_a_out_i[4], gpio_a_dir_i[4]); // RULE5
    pa_drv[3] = pick2(code3, gpio_drv(gpio_a_out_i[3], gpio_a_dir_i[3]),
                      '{out: pa_periph_i.chip_select_seven_n, oe_n: 1'b0},
                      '{out: 1'b1, oe_n: 1'b1}); // RULE6
    pa_drv[2] = pick2(code2, gpio_drv(gpio_a_out_i[2], gpio_a_dir_i[2]),
                      '{out: pa_periph_i.chip_select_six_n, oe_n: 1'b0},
                      '{out: pa_periph_i.timer0_capcomp_b_out,
                        oe_n: pa_periph_i.timer0_capcomp_b_oe_n}); // RULE8 RULE15
    pa_drv[1] = pick2(code1, gpio_drv(gpio_a_out_i[1], gpio_a_dir_i[1]),
                      '{out: pa_periph_i.chip_select_five_n, oe_n: 1'b0},
                      '{out: pa_periph_i.row_addr_strobe_n, oe_n: 1'b0}); // RULE9
    pa_drv[0] = pick2(code0, gpio_drv(gpio_a_out_i[0], gpio_a_dir_i[0]),
                      '{out: pa_periph_i.chip_select_four_n, oe_n: 1'b0},
                      '{out: pa_periph_i.timer0_capcomp_a_out,
                        oe_n: pa_periph_i.timer0_capcomp_a_oe_n}); // RULE10 RULE15
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    // registers change only by bus write; reset is power-on only
    if (acc.wr && hit(acc.addr, FSEL_OFF)) begin
      next_st.fsel = hwdata_i[15:0] | FSEL_RSVD; // RULE1 RULE14
    end
    if (acc.wr && hit(acc.addr, PBDIR_OFF)) begin
      next_st.pbdir = hwdata_i[15:0]; // RULE11 RULE13
    end
    // read data is captured in the wait state; unmapped reads zero
    if (acc.load) begin
      if (hit(acc.addr, FSEL_OFF)) begin
        next_st.hrdata = {16'h0000, st.fsel | FSEL_RSVD}; // RULE1
      end else if (hit(acc.addr, PBDIR_OFF)) begin
        next_st.hrdata = {16'h0000, st.pbdir};
      end else begin
        next_st.hrdata = HRDATA_RST;
      end
    end
    // port a drive, one cycle behind the selected source
    for (int k = 0; k < 8; k++) begin
      next_st.pa_out[k] = pa_drv[k].out;
      next_st.pa_oe_n[k] = pa_drv[k].oe_n;
    end
    next_st.pa_pullup = (code3 == FN_ALT2) & wait_pullup_en_i; // RULE7
    // port a inputs go only to the function that owns the pin
    next_st.gpio_a_in[7] = ~st.fsel[PIN7_BIT] & pa_sync[7]; // RULE15
    next_st.gpio_a_in[6] = ~st.fsel[PIN6_BIT] & pa_sync[6];
    next_st.gpio_a_in[5] = ~st.fsel[PIN5_BIT] & pa_sync[5];
    next_st.gpio_a_in[4] = ~st.fsel[PIN4_BIT] & pa_sync[4];
    next_st.gpio_a_in[3] = (code3 == FN_GPIO) & pa_sync[3];
    next_st.gpio_a_in[2] = (code2 == FN_GPIO) & pa_sync[2];
    next_st.gpio_a_in[1] = (code1 == FN_GPIO) & pa_sync[1];
    next_st.gpio_a_in[0] = (code0 == FN_GPIO) & pa_sync[0];
    // an idle wait input reads as not waiting
    next_st.wait_n = (code3 == FN_ALT2) ? pa_sync[3] : 1'b1; // RULE6 RULE15
    next_st.tmr_b_in = (code2 == FN_ALT2) & pa_sync[2]; // RULE8
    next_st.tmr_a_in = (code0 == FN_ALT2) & pa_sync[0]; // RULE10
    // port b: direction bit only where the function admits it
    for (int k = 0; k < 16; k++) begin
      next_st.pb_out[k] = pb_src_out_i[k];
      next_st.pb_oe_n[k] = pb_dir_en_i[k] ? ~st.pbdir[k] : pb_periph_oe_n_i[k]; // RULE11 RULE12
    end
    next_st.pb_in = pb_sync;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= ST_RST; // RULE13 RULE14
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hresp_o = HRESP_OKAY;
  assign hrdata_o = st.hrdata;
  assign gpio_a_in_o = st.gpio_a_in;
  assign wait_n_o = st.wait_n;
  assign timer0_capcomp_a_in_o = st.tmr_a_in;
  assign timer0_capcomp_b_in_o = st.tmr_b_in;
  assign pa_pin_o = st.pa_out;
  assign pa_pin_oe_n_o = st.pa_oe_n;
  assign pa3_pullup_o = st.pa_pullup;
  assign pb_in_o = st.pb_in;
  assign pb_pin_o = st.pb_out;
  assign pb_pin_oe_n_o = st.pb_oe_n;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence fsel_write;
    hsel_i && htrans_i[1] && hwrite_i && hready_i && hit(haddr_i, FSEL_OFF) ##1 hreadyout_o;
  endsequence

  sequence pbdir_write;
    hsel_i && htrans_i[1] && hwrite_i && hready_i && hit(haddr_i, PBDIR_OFF) ##1 hreadyout_o;
  endsequence

  sequence fsel_read;
    hsel_i && htrans_i[1] && !hwrite_i && hready_i && hit(haddr_i, FSEL_OFF) ##1 !hreadyout_o;
  endsequence

  rsvd_read_ones_a: assert property (fsel_read ##1 hreadyout_o |-> (hrdata_o[15:0] & FSEL_RSVD) == FSEL_RSVD) // RULE1
    else $error("reserved function bits did not read as one");

  pin7_route_a: assert property (st.fsel[PIN7_BIT] |=> !pa_pin_oe_n_o[7] && pa_pin_o[7] == $past(pa_periph_i.bus_grant_ack_n)) // RULE2
    else $error("pin 7 not carrying bus grant acknowledge");

  pin6_route_a: assert property (st.fsel[PIN6_BIT] |=> !pa_pin_oe_n_o[6] && pa_pin_o[6] == $past(pa_periph_i.read_strobe_n)) // RULE3
    else $error("pin 6 not carrying read strobe");

  pin5_io_a: assert property (!st.fsel[PIN5_BIT] |=> pa_pin_oe_n_o[5] == !$past(gpio_a_dir_i[5])) // RULE4
    else $error("pin 5 general io direction wrong");

  pin4_route_a: assert property (st.fsel[PIN4_BIT] |=> !pa_pin_oe_n_o[4] && pa_pin_o[4] == $past(pa_periph_i.lower_write_strobe_n)) // RULE5
    else $error("pin 4 not carrying write strobe");

  pin3_wait_a: assert property (code3 == FN_ALT2 |=> pa_pin_oe_n_o[3] && wait_n_o == $past(pa_sync[3])) // RULE6
    else $error("pin 3 wait function wrong");

  pullup_gate_a: assert property (code3 != FN_ALT2 |=> !pa3_pullup_o) // RULE7
    else $error("pin 3 pull-up on outside wait function");

  pin2_timer_a: assert property (code2 == FN_ALT2 |=> pa_pin_oe_n_o[2] == $past(pa_periph_i.timer0_capcomp_b_oe_n)) // RULE8
    else $error("pin 2 timer enable not passed");

  pin1_strobe_a: assert property (code1 == FN_ALT2 |=> !pa_pin_oe_n_o[1] && pa_pin_o[1] == $past(pa_periph_i.row_addr_strobe_n)) // RULE9
    else $error("pin 1 row strobe not routed");

  pin0_select_a: assert property (code0 == FN_ALT1 |=> !pa_pin_oe_n_o[0] && pa_pin_o[0] == $past(pa_periph_i.chip_select_four_n)) // RULE10
    else $error("pin 0 chip select not routed");

  pb_dir_used_a: assert property (pb_dir_en_i[15] && st.pbdir[15] |=> !pb_pin_oe_n_o[15]) // RULE11
    else $error("port b direction one did not drive");

  pb_dir_ignored_a: assert property (!pb_dir_en_i[0] |=> pb_pin_oe_n_o[0] == $past(pb_periph_oe_n_i[0])) // RULE12
    else $error("port b direction not ignored");

  pbdir_write_a: assert property (pbdir_write |=> st.pbdir == $past(hwdata_i[15:0])) // RULE13
    else $error("port b direction write lost");

  fsel_write_a: assert property (fsel_write |=> st.fsel == ($past(hwdata_i[15:0]) | FSEL_RSVD)) // RULE14
    else $error("function register write lost");

  gpio_in_block_a: assert property (st.fsel[PIN7_BIT] |=> !gpio_a_in_o[7]) // RULE15
    else $error("general io sees a peripheral pin");

endmodule : ppfs_top

/* File: ppfs_pin_model.sv */
`timescale 1ns/1ps
module ppfs_pin_model import ppfs_pkg::*; (
  // clock
  input wire logic mclk_i,
  // device side drive
  input wire logic [7:0] pa_out_i,
  input wire logic [7:0] pa_oe_n_i,
  input wire logic pa3_pullup_i,
  input wire logic [15:0] pb_out_i,
  input wire logic [15:0] pb_oe_n_i,
  // far side drive
  input wire logic [7:0] ext_a_i,
  input wire logic [7:0] ext_a_en_i,
  input wire logic [15:0] ext_b_i,
  // resolved pin levels
  output logic [7:0] pa_lvl_o,
  output logic [15:0] pb_lvl_o
);
  logic [7:0] pa_last;

  // ---------------------------------------------------------------
  // wire resolution
  // ---------------------------------------------------------------
  // a floating pin shows the inverse of its last level so a stale value never passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pa_oe_n_i[i]) pa_lvl_o[i] = pa_out_i[i];
      else if (ext_a_en_i[i]) pa_lvl_o[i] = ext_a_i[i];
      else if (i == 3 && pa3_pullup_i) pa_lvl_o[i] = 1'b1;
      else pa_lvl_o[i] = ~pa_last[i];
    end
  end

  // port b devices always drive a released pin
  assign pb_lvl_o = (~pb_oe_n_i & pb_out_i) | (pb_oe_n_i & ext_b_i);

  always_ff @(posedge mclk_i) begin
    pa_last <= pa_lvl_o;
  end
endmodule : ppfs_pin_model

/* File: ppfs_top_tb.sv */
`timescale 1ns/1ps
module ppfs_top_tb import ppfs_pkg::*; ();
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic mclk_i = 1'b0, rst_b_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, wait_pullup_en_i = 1'b0;
  logic hready_i, hreadyout_o, wait_n_o, timer0_capcomp_a_in_o, timer0_capcomp_b_in_o, pa3_pullup_o;
  logic [1:0] htrans_i = 2'h0;
  logic [1:0] hresp_o;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, r;
  logic [7:0] gpio_a_out_i = 8'h00, gpio_a_dir_i = 8'h00, ext_a = 8'h00;
  logic [7:0] gpio_a_in_o, pa_pin_i, pa_pin_o, pa_pin_oe_n_o;
  logic [15:0] pb_dir_en_i = 16'h0000, pb_src_out_i = 16'h0000, pb_periph_oe_n_i = 16'h0000;
  logic [15:0] ext_b = 16'h0000, pb_in_o, pb_pin_i, pb_pin_o, pb_pin_oe_n_o, fs, pbd;
  ppfs_pa_periph_t pa_periph_i = '0;
  integer seed = 12, mismatches = 0, check_count = 0;
  logic probe = 1'b0, rd_pend = 1'b0;
  logic [33:0] bus_q[$];
  logic [159:0] pin_q[$];

  // single slave: its ready is the bus ready
  assign hready_i = hreadyout_o;

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  ppfs_top DUT (.mclk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i,
    .hreadyout_o, .hresp_o, .hrdata_o, .gpio_a_out_i, .gpio_a_dir_i, .gpio_a_in_o, .pa_periph_i,
    .wait_pullup_en_i, .wait_n_o, .timer0_capcomp_a_in_o, .timer0_capcomp_b_in_o, .pa_pin_i, .pa_pin_o,
    .pa_pin_oe_n_o, .pa3_pullup_o, .pb_dir_en_i, .pb_src_out_i, .pb_periph_oe_n_i, .pb_in_o, .pb_pin_i,
    .pb_pin_o, .pb_pin_oe_n_o);

  ppfs_pin_model PEER (.mclk_i, .pa_out_i(pa_pin_o), .pa_oe_n_i(pa_pin_oe_n_o), .pa3_pullup_i(pa3_pullup_o),
    .pb_out_i(pb_pin_o), .pb_oe_n_i(pb_pin_oe_n_o), .ext_a_i(ext_a), .ext_a_en_i(8'hff), .ext_b_i(ext_b),
    .pa_lvl_o(pa_pin_i), .pb_lvl_o(pb_pin_i));

  // ---------------------------------------------------------------
  // comparison
  // ---------------------------------------------------------------
  task automatic report(input logic [79:0] got, input logic [79:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : report

  task automatic check_bus();
    logic [33:0] x;
    x = bus_q.pop_front();
    report({46'h0, hresp_o, hrdata_o}, {46'h0, x});
  endtask : check_bus

  // only pins that the block drives have a defined output value
  task automatic check_pins();
    logic [159:0] x;
    x = pin_q.pop_front();
    report(x[159:80] & {pa3_pullup_o, pa_pin_oe_n_o, pa_pin_o, pb_pin_oe_n_o, pb_pin_o, gpio_a_in_o, wait_n_o,
      timer0_capcomp_a_in_o, timer0_capcomp_b_in_o, pb_in_o, 4'h0}, x[79:0]);
  endtask : check_pins

  // watcher: read data is taken at the edge that closes its data phase
  always @(posedge mclk_i) begin
    if (probe) check_pins();
    if (hreadyout_o === 1'b1) begin
      if (rd_pend) check_bus();
      rd_pend <= hsel_i & htrans_i[1] & ~hwrite_i;
    end
  end

  // ---------------------------------------------------------------
  // bus master
  // ---------------------------------------------------------------
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 16);
    if (hreadyout_o !== 1'b1) mismatches++;
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    if (!wr) bus_q.push_back({HRESP_OKAY, exp});
    wait_ready();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_ready();
  endtask : bus

  // ---------------------------------------------------------------
  // expected pin state from the selected functions
  // ---------------------------------------------------------------
  function automatic logic [1:0] sel(input logic [1:0] c, g, a1, a2);
    case (c)
      2'h0: sel = g;
      2'h1: sel = a1;
      2'h2: sel = a2;
      default: sel = 2'h3;
    endcase
  endfunction : sel

  task automatic expect_pins();
    logic [1:0] d [8];
    logic [7:0] eo, ee, lv, gm;
    logic [15:0] bo, blv;
    for (int i = 0; i < 8; i++) d[i] = {gpio_a_out_i[i], ~gpio_a_dir_i[i]};
    d[7] = sel({1'b0, fs[14]}, d[7], {pa_periph_i.bus_grant_ack_n, 1'b0}, 2'h3);
    d[6] = sel({1'b0, fs[12]}, d[6], {pa_periph_i.read_strobe_n, 1'b0}, 2'h3);
    d[5] = sel({1'b0, fs[10]}, d[5], {pa_periph_i.upper_write_strobe_n, 1'b0}, 2'h3);
    d[4] = sel({1'b0, fs[8]}, d[4], {pa_periph_i.lower_write_strobe_n, 1'b0}, 2'h3);
    d[3] = sel(fs[7:6], d[3], {pa_periph_i.chip_select_seven_n, 1'b0}, 2'h3);
    d[2] = sel(fs[5:4], d[2], {pa_periph_i.chip_select_six_n, 1'b0},
      {pa_periph_i.timer0_capcomp_b_out, pa_periph_i.timer0_capcomp_b_oe_n});
    d[1] = sel(fs[3:2], d[1], {pa_periph_i.chip_select_five_n, 1'b0}, {pa_periph_i.row_addr_strobe_n, 1'b0});
    d[0] = sel(fs[1:0], d[0], {pa_periph_i.chip_select_four_n, 1'b0},
      {pa_periph_i.timer0_capcomp_a_out, pa_periph_i.timer0_capcomp_a_oe_n});
    gm = {~fs[14], ~fs[12], ~fs[10], ~fs[8], fs[7:6] == 2'h0, fs[5:4] == 2'h0, fs[3:2] == 2'h0, fs[1:0] == 2'h0};
    for (int i = 0; i < 8; i++) begin
      eo[i] = d[i][1];
      ee[i] = d[i][0];
    end
    lv = (ee & ext_a) | (~ee & eo);
    bo = (pb_dir_en_i & ~pbd) | (~pb_dir_en_i & pb_periph_oe_n_i);
    blv = (bo & ext_b) | (~bo & pb_src_out_i);
    pin_q.push_back({1'b1, 8'hff, ~ee, 16'hffff, ~bo, 8'hff, 3'h7, 16'hffff, 4'h0,
      (fs[7:6] == 2'h2) & wait_pullup_en_i, ee, eo & ~ee, bo, pb_src_out_i & ~bo, lv & gm,
      (fs[7:6] == 2'h2) ? lv[3] : 1'b1, (fs[1:0] == 2'h2) & lv[0], (fs[5:4] == 2'h2) & lv[2], blv, 4'h0});
    probe <= 1'b1;
    @(posedge mclk_i);
    probe <= 1'b0;
  endtask : expect_pins

  // ---------------------------------------------------------------
  // closing
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk_i);
    mismatches++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    fs = FSEL_RST;
    pbd = PBDIR_RST;
    bus(1'b0, FSEL_OFF, 32'h0, {16'h0, FSEL_RST});
    bus(1'b0, PBDIR_OFF, 32'h0, {16'h0, PBDIR_RST});
    repeat (6) @(posedge mclk_i);
    expect_pins();
    $display("test reset_values done");
    // zeros written to the reserved bits still read back as ones
    bus(1'b1, FSEL_OFF, 32'hffff_0000, 32'h0);
    bus(1'b0, FSEL_OFF, 32'h0, {16'h0, FSEL_RSVD});
    bus(1'b1, 32'h0000_0008, 32'h1234_5678, 32'h0);
    bus(1'b0, 32'h0000_0008, 32'h0, 32'h0);
    bus(1'b0, FSEL_OFF, 32'h0, {16'h0, FSEL_RSVD});
    $display("test reserved_bits done");
    // first four passes walk every function code, the rest are random
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      gpio_a_out_i <= r[7:0];
      gpio_a_dir_i <= r[15:8];
      ext_a <= r[23:16];
      wait_pullup_en_i <= r[24];
      r = $random(seed);
      pa_periph_i <= ppfs_pa_periph_t'(r[12:0]);
      pb_dir_en_i <= r[31:16];
      r = $random(seed);
      pb_src_out_i <= r[15:0];
      pb_periph_oe_n_i <= r[31:16];
      r = $random(seed);
      ext_b <= r[15:0];
      pbd = r[31:16];
      r = $random(seed);
      if (i < 4) fs = {8'haa | (i[0] ? 8'h55 : 8'h00), {4{i[1:0]}}};
      else fs = r[15:0] | FSEL_RSVD;
      bus(1'b1, FSEL_OFF, {16'hffff, fs}, 32'h0);
      bus(1'b1, PBDIR_OFF, {16'hffff, pbd}, 32'h0);
      bus(1'b0, PBDIR_OFF, 32'h0, {16'h0, pbd});
      bus(1'b0, FSEL_OFF, 32'h0, {16'h0, fs});
      repeat (6) @(posedge mclk_i);
      expect_pins();
    end
    $display("test function_select done");
    // power-on reset in mid-run restores both registers and the pins
    rst_b_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    fs = FSEL_RST;
    pbd = PBDIR_RST;
    bus(1'b0, FSEL_OFF, 32'h0, {16'h0, FSEL_RST});
    bus(1'b0, PBDIR_OFF, 32'h0, {16'h0, PBDIR_RST});
    repeat (6) @(posedge mclk_i);
    expect_pins();
    $display("test second_reset done");
    complete_run();
  end
endmodule : ppfs_top_tb
